// File: core/llsc_cfg.svh
// constants for the locked-load / conditional-store logic
// assumes a single core clock at 250 MHz and a synchronous reset
// What this block does
// - no lock register; lock lives in dcache
// - locked-load miss fetches block, fills clean if block not present
// - conditional store succeeds only if present, writable
// - commands only for nonspeculative conditional stores
// - locked load orders like store; wait bit
// - instruction fetch index match goes noncached
// - interrupting conditional stores fail in order
// - older eviction causes replay, abort locked load
// - stall map stage until queue empty
// - fetch flag forces branch fall-through prediction
// - conditional store miss: no command, fail
// - make-writable after retire, older stores writable
// - hold line against probes until written
// - conservative mode blocks speculative miss allocation
// - periodic mode runs 8-bit primary counter
// - backup counter forces 16K of 2M cycles
// - clearing field resets backup counter
// - system answers ok or fail; act accordingly
`ifndef LLSC_CFG_SVH
`define LLSC_CFG_SVH
`define LLSC_ADDR_WR_OFS    8'h00
`define LLSC_ADDR_RD_OFS    8'h04
`define LLSC_ADDR_BAD_OFS   8'h08
`define LLSC_MODE_LSB       0
`define LLSC_MODE_W         2
`define LLSC_MODE_RST       2'h0
`define LLSC_PRI_W          8
`define LLSC_PRI_THRESH     8'hFF
`define LLSC_BKP_W          21
`define LLSC_BKP_PERIOD     21'h1FFFFF
`define LLSC_BKP_WINDOW     21'h003FFF
`define LLSC_RESP_OKAY      2'h0
`define LLSC_RESP_SLVERR    2'h2
`endif

// File: core/llsc_pkg.sv
// types shared by the locked-load / conditional-store logic
// assumes the constants header is included by users
package llsc_pkg;
  typedef enum logic [1:0] {
    LLSC_MODE_OFF,
    LLSC_MODE_FULL,
    LLSC_MODE_PERIODIC,
    LLSC_MODE_RSVD
  } llsc_mode_e;
  typedef enum logic [1:0] {
    LLSC_ST_IDLE,
    LLSC_ST_WAIT_RETIRE,
    LLSC_ST_WAIT_RESP,
    LLSC_ST_HOLD_LINE
  } llsc_state_e;
  typedef struct packed {
    logic        valid;
    logic [11:0] index;
  } llsc_ref_s;
endpackage : llsc_pkg

// File: core/llsc_core.sv
// locked-load / conditional-store control with axi4-lite mode register
// assumes core-side strobes are single-cycle and synchronous to CLK_I
`timescale 1ns/10ps
`include "llsc_cfg.svh"
module llsc_core (
  // clock and reset
  input  wire logic             CLK_I,
  input  wire logic             RST_I,
  // axi4-lite slave
  input  wire logic             AWVALID_I,
  output logic                  AWREADY_O,
  input  wire logic [7:0]       AWADDR_I,
  input  wire logic             WVALID_I,
  output logic                  WREADY_O,
  input  wire logic [31:0]      WDATA_I,
  input  wire logic [3:0]       WSTRB_I,
  output logic                  BVALID_O,
  input  wire logic             BREADY_I,
  output logic [1:0]            BRESP_O,
  input  wire logic             ARVALID_I,
  output logic                  ARREADY_O,
  input  wire logic [7:0]       ARADDR_I,
  output logic                  RVALID_O,
  input  wire logic             RREADY_I,
  output logic [31:0]           RDATA_O,
  output logic [1:0]            RRESP_O,
  // locked load
  input  wire llsc_pkg::llsc_ref_s LDL_I,
  input  wire logic             LDL_MISS_I,
  input  wire logic             LDL_PRESENT_I,
  output logic                  READ_BLOCK_CMD_O,
  output logic                  FILL_CLEAN_O,
  // other memory references and issue
  input  wire llsc_pkg::llsc_ref_s MEMREF_I,
  input  wire logic             MEMREF_OLDER_I,
  input  wire logic             MEMREF_SPEC_STORE_I,
  input  wire logic             ISSUE_QUEUE_EMPTY_I,
  output logic                  REPLAY_TRAP_O,
  output logic                  ABORT_LDL_O,
  output logic                  STORE_WAIT_BIT_O,
  output logic                  LDL_AS_STORE_O,
  output logic                  MAP_STALL_O,
  output logic                  MISS_ALLOC_BLOCK_O,
  // instruction fetch and branches
  input  wire llsc_pkg::llsc_ref_s IFETCH_I,
  output logic                  IFETCH_NONCACHED_O,
  output logic                  PREDICT_FALLTHRU_O,
  input  wire logic             BR_MISPREDICT_I,
  input  wire logic             BR_COND_RETIRE_I,
  // conditional store
  input  wire llsc_pkg::llsc_ref_s STC_I,
  input  wire logic             STC_SPEC_I,
  input  wire logic             STC_HIT_I,
  input  wire logic             STC_DIRTY_I,
  input  wire logic             STC_RETIRED_I,
  input  wire logic             OLDER_STQ_WRITABLE_I,
  input  wire logic             STC_DATA_WRITTEN_I,
  output logic                  MAKE_WRITABLE_CMD_O,
  output logic                  STC_WRITE_DCACHE_O,
  output logic                  STC_DONE_O,
  output logic                  STC_SUCCESS_O,
  output logic                  PROBE_HOLD_O,
  // system controller answers
  input  wire logic             MAKE_WRITABLE_OK_RESP_I,
  input  wire logic             MAKE_WRITABLE_FAIL_RESP_I,
  input  wire logic             PROBE_INVAL_I,
  input  wire logic [11:0]      PROBE_INDEX_I
);

  // lock state: a valid flag, the locked index and a broken flag, no lock register
  logic                 lock_valid_q, lock_valid_d;
  logic [11:0]          lock_index_q, lock_index_d;
  logic                 fetch_flag_q, fetch_flag_d;
  logic                 broken_q, broken_d;
  llsc_pkg::llsc_state_e state_q, state_d;
  logic                 done_q, success_q;
  logic [`LLSC_MODE_W-1:0] mode_q;
  logic [`LLSC_PRI_W-1:0]  pri_q;
  logic [`LLSC_BKP_W-1:0]  bkp_q;
  logic                 pri_trip_q;

  function automatic logic idx_hit(input llsc_pkg::llsc_ref_s r, input logic [11:0] idx);
    idx_hit = r.valid && (r.index == idx);
  endfunction : idx_hit

  wire lock_hit_mem   = lock_valid_q && idx_hit(MEMREF_I, lock_index_q);
  wire lock_hit_stc   = lock_valid_q && idx_hit(STC_I, lock_index_q);
  wire probe_kill     = PROBE_INVAL_I && lock_valid_q && (PROBE_INDEX_I == lock_index_q)
                        && (state_q != llsc_pkg::LLSC_ST_HOLD_LINE);
  wire older_evict    = lock_hit_mem && MEMREF_OLDER_I;
  wire newer_intrude  = lock_hit_mem && !MEMREF_OLDER_I;

  assign READ_BLOCK_CMD_O = LDL_I.valid && LDL_MISS_I;
  assign FILL_CLEAN_O     = LDL_I.valid && LDL_MISS_I && !LDL_PRESENT_I;
  assign REPLAY_TRAP_O    = older_evict;
  assign ABORT_LDL_O      = older_evict;
  assign LDL_AS_STORE_O   = LDL_I.valid;
  assign STORE_WAIT_BIT_O = STC_I.valid;
  assign MAP_STALL_O      = STC_I.valid || (state_q != llsc_pkg::LLSC_ST_IDLE)
                            || (lock_valid_q && !ISSUE_QUEUE_EMPTY_I);
  assign IFETCH_NONCACHED_O = lock_valid_q && idx_hit(IFETCH_I, lock_index_q);
  assign PREDICT_FALLTHRU_O = fetch_flag_q;

  // lock tracking
  always_comb
  begin
    lock_valid_d = lock_valid_q;
    lock_index_d = lock_index_q;
    broken_d     = broken_q;
    fetch_flag_d = fetch_flag_q;
    if (LDL_I.valid)
    begin
      fetch_flag_d = 1'b1;
    end
    else if (MEMREF_I.valid || STC_I.valid)
    begin
      fetch_flag_d = 1'b0;
    end
    if (newer_intrude)
    begin
      broken_d = 1'b1;
    end
    if (older_evict || probe_kill || STC_DONE_O)
    begin
      lock_valid_d = 1'b0;
    end
    if (LDL_I.valid)
    begin
      lock_valid_d = 1'b1;
      lock_index_d = LDL_I.index;
      broken_d     = 1'b0;
    end
  end

  // conditional store sequencing
  wire stc_fail_now = STC_I.valid && (!STC_HIT_I || !lock_hit_stc || broken_q || STC_SPEC_I);
  always_comb
  begin
    state_d = state_q;
    unique case (state_q)
      llsc_pkg::LLSC_ST_IDLE:
        if (STC_I.valid && !stc_fail_now)
        begin
          state_d = STC_DIRTY_I ? llsc_pkg::LLSC_ST_HOLD_LINE : llsc_pkg::LLSC_ST_WAIT_RETIRE;
        end
      llsc_pkg::LLSC_ST_WAIT_RETIRE:
        if (!lock_valid_q)
        begin
          state_d = llsc_pkg::LLSC_ST_IDLE;
        end
        else if (STC_RETIRED_I && OLDER_STQ_WRITABLE_I)
        begin
          state_d = llsc_pkg::LLSC_ST_WAIT_RESP;
        end
      llsc_pkg::LLSC_ST_WAIT_RESP:
        if (MAKE_WRITABLE_OK_RESP_I)
        begin
          state_d = llsc_pkg::LLSC_ST_HOLD_LINE;
        end
        else if (MAKE_WRITABLE_FAIL_RESP_I)
        begin
          state_d = llsc_pkg::LLSC_ST_IDLE;
        end
      llsc_pkg::LLSC_ST_HOLD_LINE:
        if (STC_DATA_WRITTEN_I)
        begin
          state_d = llsc_pkg::LLSC_ST_IDLE;
        end
    endcase
  end

  assign MAKE_WRITABLE_CMD_O = (state_q == llsc_pkg::LLSC_ST_WAIT_RETIRE) && lock_valid_q
                               && STC_RETIRED_I && OLDER_STQ_WRITABLE_I;
  assign PROBE_HOLD_O       = (state_q == llsc_pkg::LLSC_ST_HOLD_LINE);
  assign STC_WRITE_DCACHE_O = (state_q == llsc_pkg::LLSC_ST_HOLD_LINE);

  wire fin_ok   = (state_q == llsc_pkg::LLSC_ST_HOLD_LINE) && STC_DATA_WRITTEN_I;
  wire fin_fail = stc_fail_now
                  || ((state_q == llsc_pkg::LLSC_ST_WAIT_RESP) && MAKE_WRITABLE_FAIL_RESP_I)
                  || ((state_q == llsc_pkg::LLSC_ST_WAIT_RETIRE) && !lock_valid_q);
  assign STC_DONE_O    = done_q;
  assign STC_SUCCESS_O = success_q;

  wire mode_off  = (mode_q == `LLSC_MODE_W'(llsc_pkg::LLSC_MODE_OFF));
  wire mode_full = (mode_q == `LLSC_MODE_W'(llsc_pkg::LLSC_MODE_FULL));
  wire mode_per  = (mode_q == `LLSC_MODE_W'(llsc_pkg::LLSC_MODE_PERIODIC));
  wire bkp_force = mode_per && (bkp_q <= `LLSC_BKP_WINDOW);
  wire conservative = mode_full || (mode_per && pri_trip_q) || bkp_force;
  assign MISS_ALLOC_BLOCK_O = conservative && MEMREF_SPEC_STORE_I;

  // axi4-lite slave, one access of each kind at a time
  logic aw_got_q, w_got_q;
  logic [7:0]  aw_addr_q;
  logic [31:0] w_data_q;
  logic [3:0]  w_strb_q;
  wire  do_wr   = aw_got_q && w_got_q && !BVALID_O;
  wire  wr_mode = (aw_addr_q == `LLSC_ADDR_WR_OFS);
  wire  wr_hit  = wr_mode || (aw_addr_q == `LLSC_ADDR_RD_OFS) || (aw_addr_q == `LLSC_ADDR_BAD_OFS);
  wire  mode_we = do_wr && wr_mode && w_strb_q[0];
  wire [`LLSC_MODE_W-1:0] mode_new = w_data_q[`LLSC_MODE_LSB +: `LLSC_MODE_W];
  assign AWREADY_O = !aw_got_q && !BVALID_O;
  assign WREADY_O  = !w_got_q && !BVALID_O;
  assign ARREADY_O = !RVALID_O;
  wire [31:0] rd_val =
    (ARADDR_I == `LLSC_ADDR_WR_OFS) ? {30'h0, mode_q} :
    (ARADDR_I == `LLSC_ADDR_RD_OFS) ? {8'h0, pri_q, lock_valid_q, fetch_flag_q,
                                       conservative, 1'h0, bkp_q[20:9]} :
    32'h0;
  wire rd_hit = (ARADDR_I == `LLSC_ADDR_WR_OFS) || (ARADDR_I == `LLSC_ADDR_RD_OFS);

  always_ff @(posedge CLK_I)
  begin
    if (RST_I)
    begin
      aw_got_q  <= 1'b0;
      w_got_q   <= 1'b0;
      aw_addr_q <= 8'h00;
      w_data_q  <= 32'h0;
      w_strb_q  <= 4'h0;
      BVALID_O  <= 1'b0;
      BRESP_O   <= `LLSC_RESP_OKAY;
      RVALID_O  <= 1'b0;
      RDATA_O   <= 32'h0;
      RRESP_O   <= `LLSC_RESP_OKAY;
    end
    else
    begin
      if (AWVALID_I && AWREADY_O)
      begin
        aw_got_q  <= 1'b1;
        aw_addr_q <= AWADDR_I;
      end
      if (WVALID_I && WREADY_O)
      begin
        w_got_q  <= 1'b1;
        w_data_q <= WDATA_I;
        w_strb_q <= WSTRB_I;
      end
      if (do_wr)
      begin
        aw_got_q <= 1'b0;
        w_got_q  <= 1'b0;
        BVALID_O <= 1'b1;
        BRESP_O  <= (wr_hit && aw_addr_q != `LLSC_ADDR_BAD_OFS) ? `LLSC_RESP_OKAY
                                                                : `LLSC_RESP_SLVERR;
      end
      else if (BVALID_O && BREADY_I)
      begin
        BVALID_O <= 1'b0;
      end
      if (ARVALID_I && ARREADY_O)
      begin
        RVALID_O <= 1'b1;
        RDATA_O  <= rd_val;
        RRESP_O  <= rd_hit ? `LLSC_RESP_OKAY : `LLSC_RESP_SLVERR;
      end
      else if (RVALID_O && RREADY_I)
      begin
        RVALID_O <= 1'b0;
      end
    end
  end

  // lock and store state
  always_ff @(posedge CLK_I)
  begin
    if (RST_I)
    begin
      lock_valid_q <= 1'b0;
      lock_index_q <= 12'h000;
      fetch_flag_q <= 1'b0;
      broken_q     <= 1'b0;
      state_q      <= llsc_pkg::LLSC_ST_IDLE;
      done_q       <= 1'b0;
      success_q    <= 1'b0;
    end
    else
    begin
      lock_valid_q <= lock_valid_d;
      lock_index_q <= lock_index_d;
      fetch_flag_q <= fetch_flag_d;
      broken_q     <= broken_d;
      state_q      <= state_d;
      done_q       <= fin_ok || fin_fail;
      success_q    <= fin_ok;
    end
  end

  // conservative-mode counters
  always_ff @(posedge CLK_I)
  begin
    if (RST_I)
    begin
      mode_q     <= `LLSC_MODE_RST;
      pri_q      <= `LLSC_PRI_W'(0);
      pri_trip_q <= 1'b0;
      bkp_q      <= `LLSC_BKP_W'(0);
    end
    else
    begin
      if (mode_we)
      begin
        mode_q <= mode_new;
      end
      if (!mode_per)
      begin
        pri_q      <= `LLSC_PRI_W'(0);
        pri_trip_q <= 1'b0;
      end
      else if ((BR_MISPREDICT_I || BR_COND_RETIRE_I) && pri_q != `LLSC_PRI_THRESH)
      begin
        pri_q <= pri_q + `LLSC_PRI_W'(1);
      end
      else if (pri_q == `LLSC_PRI_THRESH)
      begin
        pri_trip_q <= 1'b1;
      end
      if (mode_we && !mode_off && (mode_new == `LLSC_MODE_W'(llsc_pkg::LLSC_MODE_OFF)))
      begin
        bkp_q <= `LLSC_BKP_W'(0);
      end
      else if (mode_per)
      begin
        bkp_q <= (bkp_q == `LLSC_BKP_PERIOD) ? `LLSC_BKP_W'(0) : bkp_q + `LLSC_BKP_W'(1);
      end
    end
  end

endmodule : llsc_core

// File: test/llsc_sysctl_model.sv
// system controller stand-in for make-writable requests and probes
// assumes one request outstanding; bench sets latency and verdict
`timescale 1ns/10ps
module llsc_sysctl_model (
  // clock and reset
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  // bench controls
  input  wire logic [3:0]  lat_i,
  input  wire logic        fail_i,
  input  wire logic        mod_i,
  input  wire logic [11:0] idx_i,
  // device side
  input  wire logic        cmd_i,
  output logic             ok_o,
  output logic             fail_o,
  output logic             probe_o,
  output logic [11:0]      probe_idx_o
);
  logic       pend_q;
  logic [3:0] cnt_q;
  always @(posedge clk_i)
  begin
    ok_o <= 1'h0;
    fail_o <= 1'h0;
    probe_o <= mod_i & ~rst_i;
    // index is meaningless between probes, so keep it moving
    probe_idx_o <= rst_i ? 12'h000 : (mod_i ? idx_i : ~probe_idx_o);
    if (rst_i)
      pend_q <= 1'h0;
    else if (cmd_i)
      {pend_q, cnt_q} <= {1'h1, lat_i};
    else if (pend_q && cnt_q == 4'h0)
      {pend_q, ok_o, fail_o} <= {1'h0, ~fail_i, fail_i};
    else
      cnt_q <= cnt_q - 4'h1;
  end
endmodule : llsc_sysctl_model

// File: test/llsc_core_checker.sv
// port assertions for the locked-load / conditional-store block
// assumes cond stores are only offered while the store logic is idle
`timescale 1ns/10ps
module llsc_core_checker (
  input wire logic                CLK_I,
  input wire logic                RST_I,
  input wire llsc_pkg::llsc_ref_s LDL_I,
  input wire logic                LDL_MISS_I,
  input wire logic                READ_BLOCK_CMD_O,
  input wire llsc_pkg::llsc_ref_s MEMREF_I,
  input wire logic                MEMREF_OLDER_I,
  input wire logic                MEMREF_SPEC_STORE_I,
  input wire logic                REPLAY_TRAP_O,
  input wire logic                ABORT_LDL_O,
  input wire logic                MAP_STALL_O,
  input wire logic                MISS_ALLOC_BLOCK_O,
  input wire logic                STORE_WAIT_BIT_O,
  input wire logic                PREDICT_FALLTHRU_O,
  input wire llsc_pkg::llsc_ref_s STC_I,
  input wire logic                STC_SPEC_I,
  input wire logic                STC_HIT_I,
  input wire logic                STC_RETIRED_I,
  input wire logic                OLDER_STQ_WRITABLE_I,
  input wire logic                STC_DATA_WRITTEN_I,
  input wire logic                MAKE_WRITABLE_CMD_O,
  input wire logic                STC_DONE_O,
  input wire logic                STC_SUCCESS_O,
  input wire logic                PROBE_HOLD_O,
  input wire logic                MAKE_WRITABLE_FAIL_RESP_I,
  input wire logic                MAKE_WRITABLE_OK_RESP_I,
  input wire logic                LDL_PRESENT_I,
  input wire logic                FILL_CLEAN_O,
  input wire logic                LDL_AS_STORE_O,
  input wire logic                ISSUE_QUEUE_EMPTY_I,
  input wire logic                STC_WRITE_DCACHE_O
);
  default clocking cb @(posedge CLK_I); endclocking
  default disable iff (RST_I);
  sequence s_fail; STC_DONE_O && !STC_SUCCESS_O; endsequence
  sequence s_ok; STC_DONE_O && STC_SUCCESS_O; endsequence
  sequence s_lock_busy; LDL_I.valid ##1 !ISSUE_QUEUE_EMPTY_I; endsequence
  property p_rdcmd; READ_BLOCK_CMD_O == (LDL_I.valid && LDL_MISS_I); endproperty
  a_rdcmd: assert property (p_rdcmd) else $error("read block cmd wrong");
  property p_fill; LDL_I.valid && LDL_MISS_I |-> FILL_CLEAN_O == !LDL_PRESENT_I; endproperty
  a_fill: assert property (p_fill) else $error("clean fill wrong");
  property p_ldst; LDL_I.valid |-> LDL_AS_STORE_O; endproperty
  a_ldst: assert property (p_ldst) else $error("locked load not ordered as store");
  property p_stall; s_lock_busy |-> MAP_STALL_O; endproperty
  a_stall: assert property (p_stall) else $error("map stage not stalled");
  property p_ord; STC_I.valid |-> STORE_WAIT_BIT_O && MAP_STALL_O; endproperty
  a_ord: assert property (p_ord) else $error("store wait or stall missing");
  property p_miss; STC_I.valid && !STC_HIT_I |-> !MAKE_WRITABLE_CMD_O ##1 s_fail; endproperty
  a_miss: assert property (p_miss) else $error("missing store not failed");
  property p_spec; STC_I.valid && STC_SPEC_I |=> s_fail; endproperty
  a_spec: assert property (p_spec) else $error("speculative store not failed");
  property p_cmd; MAKE_WRITABLE_CMD_O |-> STC_RETIRED_I && OLDER_STQ_WRITABLE_I; endproperty
  a_cmd: assert property (p_cmd) else $error("make writable too early");
  property p_hold; PROBE_HOLD_O && !STC_DATA_WRITTEN_I |=> PROBE_HOLD_O; endproperty
  a_hold: assert property (p_hold) else $error("line released before write");
  property p_wr; PROBE_HOLD_O && STC_DATA_WRITTEN_I |=> s_ok; endproperty
  a_wr: assert property (p_wr) else $error("written store not reported ok");
  property p_cfail; MAKE_WRITABLE_FAIL_RESP_I |=> s_fail; endproperty
  a_cfail: assert property (p_cfail) else $error("fail answer not honoured");
  property p_trap; REPLAY_TRAP_O |-> ABORT_LDL_O && MEMREF_I.valid && MEMREF_OLDER_I; endproperty
  a_trap: assert property (p_trap) else $error("replay trap without cause");
  property p_flag; LDL_I.valid |=> PREDICT_FALLTHRU_O; endproperty
  a_flag: assert property (p_flag) else $error("fall-through flag not set");
  property p_alloc; MISS_ALLOC_BLOCK_O |-> MEMREF_SPEC_STORE_I; endproperty
  a_alloc: assert property (p_alloc) else $error("miss block without spec store");
  property p_flclr; MEMREF_I.valid && !LDL_I.valid |=> !PREDICT_FALLTHRU_O; endproperty
  a_flclr: assert property (p_flclr) else $error("fall-through flag not cleared");
  property p_okw; MAKE_WRITABLE_OK_RESP_I |=> STC_WRITE_DCACHE_O && PROBE_HOLD_O; endproperty
  a_okw: assert property (p_okw) else $error("ok answer not followed by write");
endmodule : llsc_core_checker
bind llsc_core llsc_core_checker chk_u (.*);

// File: test/testbench.sv
// self-checking bench for the locked-load / conditional-store block
// assumes the system controller model and checker are compiled first
`timescale 1ns/10ps
`include "llsc_cfg.svh"
module testbench;
  logic clk = 1'h0, rst = 1'h1, awv = 1'h0, wv = 1'h0, bry = 1'h0, arv = 1'h0, rry = 1'h0;
  logic lmiss = 1'h0, mold = 1'h0, mspec = 1'h0, iqe = 1'h1, brm = 1'h0, brc = 1'h0;
  logic sspec = 1'h0, shit = 1'h0, sdirty = 1'h0, sret = 1'h0, solder = 1'h0, swr = 1'h0;
  logic mod = 1'h0, cfl = 1'h0, awr, wrd, bv, arr, rv, mwc, dn, sok, ph, inc, ok, fl, prb;
  logic lpres = 1'h0, mab, trap;
  logic [7:0] awa = 8'h00, ara = 8'h00;
  logic [31:0] wd = 32'h0, rd;
  logic [3:0] lat = 4'h0;
  logic [11:0] pix = 12'h000, prx;
  logic [1:0] brs, rrs;
  llsc_pkg::llsc_ref_s ldl = '0, mref = '0, ifr = '0, stc = '0;
  integer seed = 32'h38ad, fails = 0, num_checks = 0, n;
  string nq[$];
  logic [33:0] eq[$], mq[$];
  // hit dirty spec cfail, mid, slow, expected success
  logic [7:0] tbl [9] = '{8'h81, 8'h83, 8'hC1, 8'h00, 8'hA0, 8'h92, 8'h84, 8'h88, 8'h8C};
  llsc_core dut_u (.CLK_I(clk), .RST_I(rst), .AWVALID_I(awv), .AWREADY_O(awr),
    .AWADDR_I(awa), .WVALID_I(wv), .WREADY_O(wrd), .WDATA_I(wd), .WSTRB_I(4'hF),
    .BVALID_O(bv), .BREADY_I(bry), .BRESP_O(brs), .ARVALID_I(arv), .ARREADY_O(arr),
    .ARADDR_I(ara), .RVALID_O(rv), .RREADY_I(rry), .RDATA_O(rd), .RRESP_O(rrs),
    .LDL_I(ldl), .LDL_MISS_I(lmiss), .LDL_PRESENT_I(lpres), .READ_BLOCK_CMD_O(),
    .FILL_CLEAN_O(), .MEMREF_I(mref), .MEMREF_OLDER_I(mold), .MEMREF_SPEC_STORE_I(mspec),
    .ISSUE_QUEUE_EMPTY_I(iqe), .REPLAY_TRAP_O(trap), .ABORT_LDL_O(), .STORE_WAIT_BIT_O(),
    .LDL_AS_STORE_O(), .MAP_STALL_O(), .MISS_ALLOC_BLOCK_O(mab), .IFETCH_I(ifr),
    .IFETCH_NONCACHED_O(inc), .PREDICT_FALLTHRU_O(), .BR_MISPREDICT_I(brm),
    .BR_COND_RETIRE_I(brc), .STC_I(stc), .STC_SPEC_I(sspec), .STC_HIT_I(shit),
    .STC_DIRTY_I(sdirty), .STC_RETIRED_I(sret), .OLDER_STQ_WRITABLE_I(solder),
    .STC_DATA_WRITTEN_I(swr), .MAKE_WRITABLE_CMD_O(mwc), .STC_WRITE_DCACHE_O(),
    .STC_DONE_O(dn), .STC_SUCCESS_O(sok), .PROBE_HOLD_O(ph), .MAKE_WRITABLE_OK_RESP_I(ok),
    .MAKE_WRITABLE_FAIL_RESP_I(fl), .PROBE_INVAL_I(prb), .PROBE_INDEX_I(prx));
  llsc_sysctl_model sys_u (.clk_i(clk), .rst_i(rst), .lat_i(lat), .fail_i(cfl),
    .mod_i(mod), .idx_i(pix), .cmd_i(mwc), .ok_o(ok), .fail_o(fl), .probe_o(prb),
    .probe_idx_o(prx));
  always #2 clk = ~clk;
  always @(posedge clk) iqe <= 1'($random(seed));
  task automatic note(string s, logic [33:0] e, logic [33:0] m);
    nq.push_back(s);
    eq.push_back(e);
    mq.push_back(m);
  endtask : note
  task automatic cmp(logic [33:0] g);
    logic [33:0] e, m;
    string s;
    s = "unexpected";
    e = ~g;
    m = 34'h3FFFFFFFF;
    if (eq.size() != 0)
    begin
      s = nq.pop_front();
      e = eq.pop_front();
      m = mq.pop_front();
    end
    num_checks++;
    if (((g ^ e) & m) !== 34'h0)
    begin
      fails++;
      $display("BAD %s exp %h got %h", s, e & m, g & m);
    end
  endtask : cmp
  // outputs are settled at the falling edge
  always @(negedge clk)
  begin
    if (!rst && dn) cmp({33'h0, sok});
    if (!rst && rv && rry) cmp({rrs, rd});
    if (!rst && bv && bry) cmp({brs, 32'h0});
    if (!rst && ifr.valid) cmp({33'h0, inc});
    if (!rst && mref.valid) cmp({33'h0, trap});
    if (!rst && mspec) cmp({33'h0, mab});
  end
  task automatic report_and_stop;
    if (fails == 0 && num_checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : report_and_stop
  task automatic axi(logic w, logic [7:0] a, logic [31:0] d);
    logic [4:0] h;
    @(posedge clk);
    if (w)
      {awv, wv, bry, awa, wd} <= {3'h7, a, d};
    else
      {arv, rry, ara} <= {2'h3, a};
    forever
    begin
      @(negedge clk);
      h = {awr & awv, wrd & wv, bv & bry, arr & arv, rv & rry};
      @(posedge clk);
      if (h[4]) awv <= 1'h0;
      if (h[3]) wv <= 1'h0;
      if (h[1]) arv <= 1'h0;
      if (h[2] | h[0]) break;
    end
    {bry, rry} <= 2'h0;
  endtask : axi
  task automatic wr(logic [31:0] d);
    note("write resp", 34'h0, 34'h300000000);
    axi(1'h1, `LLSC_ADDR_WR_OFS, d);
  endtask : wr
  task automatic rd_st(logic [33:0] e, logic [33:0] m);
    note("status", e, m);
    axi(1'h0, `LLSC_ADDR_RD_OFS, 32'h0);
  endtask : rd_st
  task automatic pair(logic [7:0] c);
    logic [11:0] i;
    i = $random(seed);
    @(posedge clk);
    {ldl, lmiss, lpres} <= {1'h1, i, 2'($random(seed))};
    @(posedge clk);
    ldl <= '0;
    {mref, mold} <= {c[3] ^ c[2], i, c[3]};
    // only the locked index may go noncached
    ifr <= {1'h1, (c[3:2] == 2'h0) ? i : ~i};
    note("noncached fetch", {33'h0, c[3:2] == 2'h0}, 34'h1);
    if (c[3] ^ c[2]) note("replay trap", {33'h0, c[3]}, 34'h1);
    @(posedge clk);
    {mref, ifr} <= '0;
    note("stc result", {33'h0, c[0]}, 34'h1);
    {stc, shit, sdirty, sspec, cfl, lat} <= {1'h1, i, c[7:4], c[1] ? 4'h7 : 4'h0};
    if (c[3:2] == 2'h3) {mod, pix} <= {1'h1, i};
    @(posedge clk);
    {stc, mod} <= '0;
    repeat (4) @(posedge clk);
    {sret, solder} <= 2'h3;
    repeat (40)
    begin
      @(negedge clk);
      if (ph | dn) break;
    end
    if (ph)
    begin
      @(posedge clk);
      {mod, pix} <= {1'h1, i};
      @(posedge clk);
      mod <= 1'h0;
      repeat (3) @(posedge clk);
      swr <= 1'h1;
      @(posedge clk);
      swr <= 1'h0;
    end
    repeat (4) @(posedge clk);
    {sret, solder} <= 2'h0;
  endtask : pair
  task automatic br(int k);
    repeat (k)
    begin
      @(posedge clk);
      {brm, brc} <= ($random(seed) & 1) ? 2'h2 : 2'h1;
      @(posedge clk);
      {brm, brc} <= 2'h0;
    end
  endtask : br
  task automatic spec_pulse(logic e);
    note("miss block", {33'h0, e}, 34'h1);
    @(posedge clk);
    mspec <= 1'h1;
    @(posedge clk);
    mspec <= 1'h0;
  endtask : spec_pulse
  initial
  begin
    repeat (16) @(posedge clk);
    rst <= 1'h0;
    note("mode reset", 34'h0, 34'h300000003);
    axi(1'h0, `LLSC_ADDR_WR_OFS, 32'h0);
    note("unmapped read", {`LLSC_RESP_SLVERR, 32'h0}, 34'h3FFFFFFFF);
    axi(1'h0, `LLSC_ADDR_BAD_OFS, 32'h0);
    note("unmapped write", {`LLSC_RESP_SLVERR, 32'h0}, 34'h300000000);
    axi(1'h1, `LLSC_ADDR_BAD_OFS, 32'h0);
    for (int k = 0; k < 9; k++) pair(tbl[k]);
    br(3);
    spec_pulse(1'h0);
    wr(($random(seed) & 32'hFFFFFFFC) | 32'h1);
    spec_pulse(1'h1);
    rd_st(34'h2000, 34'h300002000);
    wr(32'h0);
    wr(32'h2);
    n = ($random(seed) & 7) + 1;
    br(n);
    rd_st({10'h0, 8'(n), 16'h2000}, 34'h300FF2FFF);
    repeat (1200) @(posedge clk);
    rd_st(34'h2, 34'h300000FFF);
    wr(32'h0);
    wr(32'h2);
    rd_st(34'h2000, 34'h300002FFF);
    repeat (16500) @(posedge clk);
    rd_st(34'h0, 34'h300002000);
    spec_pulse(1'h0);
    br(256);
    rd_st({10'h0, 8'hFF, 16'h2000}, 34'h300FF2000);
    spec_pulse(1'h1);
    wr(32'h3);
    rd_st(34'h0, 34'h300FF2000);
    report_and_stop();
  end
  initial
  begin
    #200000;
    fails++;
    report_and_stop();
  end
endmodule : testbench
